// ---- rtl/wdg_pkg.sv ----
package wdg_pkg;

  // register map
  localparam logic [15:0] WDG_MODE_ADDR    = 16'hFF48;
  localparam logic [15:0] WDG_RESTART_ADDR = 16'hFF49;

  // reset, readback and restart key values
  localparam logic [7:0] WDG_MODE_RESET    = 8'h67;
  localparam logic [7:0] WDG_RESTART_READ  = 8'h9A;
  localparam logic [7:0] WDG_RESTART_KEY   = 8'hAC;
  localparam logic [7:0] WDG_UNMAPPED_READ = 8'h00;

  // mode register fields
  localparam int WDG_CLK_SEL_HI_BIT = 4;
  localparam int WDG_CLK_SEL_LO_BIT = 3;
  localparam int WDG_INTERVAL_MSB   = 2;
  localparam int WDG_INTERVAL_LSB   = 0;
  localparam int WDG_INTERVAL_W     = 3;

  // overflow exponent bases per clock source
  localparam logic [4:0] WDG_SLOW_EXP_BASE = 5'h0B;
  localparam logic [4:0] WDG_SYS_EXP_BASE  = 5'h0D;

  // counter sizing: largest period is two to the twentieth
  localparam int WDG_CNT_W = 20;

  // reset cause register bit that records a watchdog reset
  localparam int WDG_CAUSE_FLAG_BIT = 4;

  // lifecycle of the mode register after reset
  typedef enum logic [1:0] {
    WDG_MODE_OPEN,
    WDG_MODE_LOCKED,
    WDG_MODE_HALTED
  } wdg_mode_state_t;

  // processor access, one cycle wide
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic        bit_op;
    logic [7:0]  wdata;
  } wdg_cpu_req_t;

endpackage

// ---- rtl/wdg_sync.sv ----
`timescale 1ns/1ns
module wdg_sync
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      rise_pulse
);
  import wdg_pkg::*;

  logic meta_reg;
  logic meta_next;
  logic stable_reg;
  logic stable_next;
  logic prev_reg;
  logic prev_next;
  logic rise_reg;
  logic rise_next;

  // two-flop synchroniser, edge detect on the second stage only
  always_comb
  begin
    meta_next   = meta_reg;
    stable_next = stable_reg;
    prev_next   = prev_reg;
    rise_next   = rise_reg;
    if (ce)
    begin
      meta_next   = async_in;
      stable_next = meta_reg;
      prev_next   = stable_reg;
      rise_next   = stable_reg & ~prev_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_reg   <= 1'b0;
      stable_reg <= 1'b0;
      prev_reg   <= 1'b0;
      rise_reg   <= 1'b0;
    end
    else
    begin
      meta_reg   <= meta_next;
      stable_reg <= stable_next;
      prev_reg   <= prev_next;
      rise_reg   <= rise_next;
    end
  end

  assign rise_pulse = rise_reg;

endmodule

// ---- rtl/wdg_guard.sv ----
// Behaviour
// - mode register writable once; repeat forces reset
// - mode resets to 67H, reads current value
// - bits 4:3 pick slow, system, or stop
// - interval field picks power-of-two overflow count
// - interval field is all ones after reset
// - fixed slow oscillator ignores clock-select bits
// - stopped watchdog suppresses all misuse resets
// - key ACH clears counter, counting continues
// - wrong restart byte value forces reset
// - bit operation on restart forces reset
// - restart register always reads 9AH
// - counter overflow forces internal reset
// - watchdog reset sets cause flag bit 4
// - first mode write clears the counter
`timescale 1ns/1ns
module wdg_guard
#(
  parameter int CNT_W = wdg_pkg::WDG_CNT_W
)
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 por,
  input  wire logic                 ce,
  input  wire wdg_pkg::wdg_cpu_req_t cpu_req,
  input  wire logic                 slow_osc_clk,
  input  wire logic                 slow_osc_fixed,
  input  wire logic                 cause_clear,
  output logic [7:0]                rdata,
  output logic                      guard_reset,
  output logic                      guard_reset_flag,
  output logic                      guard_halted
);
  import wdg_pkg::*;

  wdg_mode_state_t   state_reg;
  wdg_mode_state_t   state_next;
  logic [7:0]        guard_mode_reg;
  logic [7:0]        guard_mode_next;
  logic [CNT_W-1:0]  count_reg;
  logic [CNT_W-1:0]  count_next;
  logic [7:0]        rdata_reg;
  logic [7:0]        rdata_next;
  logic              reset_out_reg;
  logic              reset_out_next;
  logic              flag_reg;
  logic              flag_next;
  logic              halted_reg;
  logic              halted_next;

  logic              slow_tick;
  logic              mode_hit;
  logic              restart_hit;
  logic              mode_wr;
  logic              restart_wr;
  logic              restart_bit_op;
  logic              use_slow;
  logic              stop_sel;
  logic              count_tick;
  logic [4:0]        exp_base;
  logic [4:0]        exponent;
  logic [CNT_W:0]    limit_full;
  logic [CNT_W-1:0]  limit_last;
  logic              overflow;
  logic              misuse;
  logic [7:0]        mode_write_val;
  logic              write_halts;

  wdg_sync u_slow_sync
  (
    .clk        (clk),
    .reset      (reset),
    .ce         (ce),
    .async_in   (slow_osc_clk),
    .rise_pulse (slow_tick)
  );

  // address decode
  always_comb
  begin
    mode_hit    = 1'b0;
    restart_hit = 1'b0;
    if (cpu_req.addr == WDG_MODE_ADDR)
    begin
      mode_hit = 1'b1;
    end
    else if (cpu_req.addr == WDG_RESTART_ADDR)
    begin
      restart_hit = 1'b1;
    end
  end

  assign mode_wr        = ce & cpu_req.wr & mode_hit;
  assign restart_wr     = ce & cpu_req.wr & restart_hit & ~cpu_req.bit_op;
  assign restart_bit_op = ce & cpu_req.wr & restart_hit & cpu_req.bit_op;

  // value stored on the single mode write
  always_comb
  begin
    mode_write_val = cpu_req.wdata;
    if (slow_osc_fixed)
    begin
      mode_write_val[WDG_CLK_SEL_HI_BIT] = 1'b0;
      mode_write_val[WDG_CLK_SEL_LO_BIT] = 1'b0;
    end
  end

  assign write_halts = mode_write_val[WDG_CLK_SEL_HI_BIT];

  // clock source and period selection
  always_comb
  begin
    stop_sel = guard_mode_reg[WDG_CLK_SEL_HI_BIT] & ~slow_osc_fixed;
    use_slow = slow_osc_fixed | ~guard_mode_reg[WDG_CLK_SEL_LO_BIT];
    if (use_slow)
    begin
      exp_base = WDG_SLOW_EXP_BASE;
    end
    else
    begin
      exp_base = WDG_SYS_EXP_BASE;
    end
    exponent = exp_base + 5'(guard_mode_reg[WDG_INTERVAL_MSB:WDG_INTERVAL_LSB]);
    limit_full = (CNT_W + 1)'(1) << exponent;
    limit_last = CNT_W'(limit_full - (CNT_W + 1)'(1));
    count_tick = ce & ~stop_sel & (use_slow ? slow_tick : 1'b1);
    overflow   = count_tick & (count_reg == limit_last);
  end

  // misuse detection, suppressed once halted
  always_comb
  begin
    misuse = 1'b0;
    if (state_reg != WDG_MODE_HALTED)
    begin
      if (mode_wr && state_reg == WDG_MODE_LOCKED)
      begin
        misuse = 1'b1;
      end
      if (restart_wr && cpu_req.wdata != WDG_RESTART_KEY)
      begin
        misuse = 1'b1;
      end
      if (restart_bit_op)
      begin
        misuse = 1'b1;
      end
    end
  end

  // mode lifecycle and mode register
  always_comb
  begin
    state_next      = state_reg;
    guard_mode_next = guard_mode_reg;
    if (mode_wr && state_reg == WDG_MODE_OPEN)
    begin
      guard_mode_next = mode_write_val;
      if (write_halts)
      begin
        state_next = WDG_MODE_HALTED;
      end
      else
      begin
        state_next = WDG_MODE_LOCKED;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg      <= WDG_MODE_OPEN;
      guard_mode_reg <= WDG_MODE_RESET;
    end
    else
    begin
      state_reg      <= state_next;
      guard_mode_reg <= guard_mode_next;
    end
  end

  // counter
  always_comb
  begin
    count_next = count_reg;
    if (mode_wr && state_reg == WDG_MODE_OPEN)
    begin
      count_next = '0;
    end
    else if (restart_wr && cpu_req.wdata == WDG_RESTART_KEY)
    begin
      count_next = '0;
    end
    else if (overflow)
    begin
      count_next = '0;
    end
    else if (count_tick)
    begin
      count_next = count_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count_reg <= '0;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  // read data
  always_comb
  begin
    rdata_next = rdata_reg;
    if (ce && cpu_req.rd)
    begin
      if (mode_hit)
      begin
        rdata_next = guard_mode_reg;
      end
      else if (restart_hit)
      begin
        rdata_next = WDG_RESTART_READ;
      end
      else
      begin
        rdata_next = WDG_UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_reg <= WDG_UNMAPPED_READ;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // internal reset request and halt status
  always_comb
  begin
    reset_out_next = reset_out_reg;
    halted_next    = halted_reg;
    if (ce)
    begin
      reset_out_next = overflow | misuse;
      halted_next    = (state_next == WDG_MODE_HALTED) | stop_sel;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reset_out_reg <= 1'b0;
      halted_reg    <= 1'b0;
    end
    else
    begin
      reset_out_reg <= reset_out_next;
      halted_reg    <= halted_next;
    end
  end

  // new watchdog reset wins over a clear in the same cycle
  always_comb
  begin
    flag_next = flag_reg;
    if (ce)
    begin
      if (cause_clear)
      begin
        flag_next = 1'b0;
      end
      if (overflow || misuse)
      begin
        flag_next = 1'b1;
      end
    end
  end

  // cause flag survives the chip reset it triggers; only power-on or cause_clear clears it
  always_ff @(posedge clk)
  begin
    if (por)
    begin
      flag_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

  assign rdata            = rdata_reg;
  assign guard_reset      = reset_out_reg;
  assign guard_reset_flag = flag_reg;
  assign guard_halted     = halted_reg;

endmodule

// ---- sim/wdg_checker.sv ----
`timescale 1ns/1ns
module wdg_checker
(
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  por,
  input wire logic                  ce,
  input wire wdg_pkg::wdg_cpu_req_t cpu_req,
  input wire logic                  slow_osc_fixed,
  input wire logic                  cause_clear,
  input wire logic [7:0]            rdata,
  input wire logic                  guard_reset,
  input wire logic                  guard_reset_flag,
  input wire logic                  guard_halted
);
  import wdg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic done_reg;
  logic done_next;
  logic mw;
  logic rw;
  logic rd_m;
  logic rd_r;
  assign mw = ce && cpu_req.wr && cpu_req.addr == WDG_MODE_ADDR;
  assign rw = ce && cpu_req.wr && cpu_req.addr == WDG_RESTART_ADDR && !guard_halted;
  assign rd_m = ce && cpu_req.rd && cpu_req.addr == WDG_MODE_ADDR;
  assign rd_r = ce && cpu_req.rd && cpu_req.addr == WDG_RESTART_ADDR;
  always_comb done_next = reset ? 1'b0 : (done_reg | mw);
  always_ff @(posedge clk) done_reg <= done_next;
  a_mode_init:
    assert property (rd_m && !done_reg |=> rdata == WDG_MODE_RESET) else $error("mode init");
  a_restart_read:
    assert property (rd_r |=> rdata == WDG_RESTART_READ) else $error("restart read");
  a_fixed_clk:
    assert property (rd_m && slow_osc_fixed |=> rdata[4:3] == 2'b00) else $error("fixed clk");
  a_second_mode:
    assert property (mw && done_reg && !guard_halted |=> guard_reset) else $error("second mode");
  a_bad_key:
    assert property (rw && !cpu_req.bit_op && cpu_req.wdata != WDG_RESTART_KEY |=> guard_reset)
      else $error("bad key");
  a_bit_restart:
    assert property (rw && cpu_req.bit_op |=> guard_reset) else $error("bit op");
  a_halt_entry:
    assert property (mw && !done_reg |=> guard_halted == ($past(cpu_req.wdata[4]) && !$past(slow_osc_fixed)))
      else $error("halt entry");
  a_halt_quiet:
    assert property (guard_halted |=> !guard_reset) else $error("halt quiet");
  a_flag_set:
    assert property (guard_reset |-> guard_reset_flag) else $error("flag set");
  a_flag_hold:
    assert property (guard_reset_flag && !por && !cause_clear |=> guard_reset_flag) else $error("flag hold");
endmodule
bind wdg_guard wdg_checker i_wdg_checker (.clk(clk), .reset(reset), .por(por), .ce(ce),
  .cpu_req(cpu_req), .slow_osc_fixed(slow_osc_fixed), .cause_clear(cause_clear), .rdata(rdata),
  .guard_reset(guard_reset), .guard_reset_flag(guard_reset_flag), .guard_halted(guard_halted));

// ---- sim/wdg_guard_tb.sv ----
`timescale 1ns/1ns
module wdg_guard_tb;
  import wdg_pkg::*;
  localparam logic [15:0] MA = WDG_MODE_ADDR;
  localparam logic [15:0] RA = WDG_RESTART_ADDR;
  logic         clk;
  logic         reset;
  logic         por;
  logic         ce;
  logic         slow_osc_clk;
  logic         slow_osc_fixed;
  logic         cause_clear;
  wdg_cpu_req_t cpu_req;
  logic [7:0]   rdata;
  logic         guard_reset;
  logic         guard_reset_flag;
  logic         guard_halted;
  logic         pend;
  logic [9:0]   exp_q[$];
  logic [9:0]   e;
  logic [7:0]   d;
  int           n_mismatch;
  int           tests_run;
  int           n_rst;
  int           n;
  int           seed;
  wdg_guard i_wdg_guard (.clk(clk), .reset(reset), .por(por), .ce(ce), .cpu_req(cpu_req),
    .slow_osc_clk(slow_osc_clk), .slow_osc_fixed(slow_osc_fixed), .cause_clear(cause_clear),
    .rdata(rdata), .guard_reset(guard_reset), .guard_reset_flag(guard_reset_flag),
    .guard_halted(guard_halted));
  task automatic check(string nm, logic [9:0] seen, logic [9:0] want);
    tests_run++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, want, seen);
    end
  endtask
  // k: 0 write, 1 read, 2 bit write; r: reset pulse expected
  task automatic op(logic [15:0] a, int k, logic [7:0] w, logic r, logic [7:0] x);
    cpu_req <= '{a, k != 1, k == 1, k == 2, w};
    exp_q.push_back({k == 1, r, x});
    @(posedge clk);
  endtask
  task automatic idle();
    cpu_req <= '0;
    repeat (2) @(posedge clk);
  endtask
  task automatic wait_pulse();
    n = 0;
    while (guard_reset !== 1'b1 && n < 9000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic rst();
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (pend)
    begin
      e = exp_q.pop_front();
      check("reset pulse", guard_reset, e[8]);
      if (e[9])
        check("read data", rdata, e[7:0]);
    end
    pend <= ce & (cpu_req.wr | cpu_req.rd) & ~reset;
    if (guard_reset === 1'b1)
      n_rst++;
    slow_osc_clk <= ~slow_osc_clk;
  end
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    seed = 32'h92CE;
    {reset, por, ce, slow_osc_clk, slow_osc_fixed, cause_clear, pend} = 7'h70;
    cpu_req = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    op(MA, 1, 8'h00, 0, WDG_MODE_RESET);
    op(MA, 1, 8'h00, 0, WDG_MODE_RESET);
    op(RA, 1, 8'h00, 0, WDG_RESTART_READ);
    op(16'hFF4A, 1, 8'h00, 0, WDG_UNMAPPED_READ);
    d = 8'($random(seed));
    if (d == WDG_RESTART_KEY)
      d = 8'h00;
    op(RA, 0, d, 1, 8'h00);
    idle();
    check("flag", guard_reset_flag, 1);
    cause_clear <= 1'b1;
    @(posedge clk);
    cause_clear <= 1'b0;
    repeat (2) @(posedge clk);
    check("flag", guard_reset_flag, 0);
    rst();
    op(RA, 2, WDG_RESTART_KEY, 1, 8'h00);
    idle();
    $display("test 1 done");
    rst();
    // let the slow count grow so a missed clear would overflow before the key
    repeat (9000) @(posedge clk);
    n = n_rst;
    op(MA, 0, 8'h68, 0, 8'h00);
    op(MA, 1, 8'h00, 0, 8'h68);
    idle();
    repeat (4000) @(posedge clk);
    op(RA, 0, WDG_RESTART_KEY, 0, 8'h00);
    check("early overflow", n_rst == n, 1'b1);
    op(RA, 1, 8'h00, 0, WDG_RESTART_READ);
    idle();
    wait_pulse();
    check("overflow", n == (1 << WDG_SYS_EXP_BASE) - 2, 1'b1);
    op(MA, 0, 8'h68, 1, 8'h00);
    idle();
    $display("test 2 done");
    rst();
    op(MA, 0, 8'h78, 0, 8'h00);
    op(MA, 0, 8'h68, 0, 8'h00);
    op(RA, 2, WDG_RESTART_KEY, 0, 8'h00);
    op(RA, 0, d, 0, 8'h00);
    op(MA, 1, 8'h00, 0, 8'h78);
    idle();
    n = n_rst;
    repeat (9000) @(posedge clk);
    check("halted", {guard_halted, n_rst == n}, 2'b11);
    $display("test 3 done");
    slow_osc_fixed <= 1'b1;
    rst();
    op(MA, 0, 8'h78, 0, 8'h00);
    op(MA, 1, 8'h00, 0, 8'h60);
    op(RA, 0, d, 1, 8'h00);
    idle();
    check("halted", guard_halted, 0);
    // two thousand and forty-eight slow ticks, two clocks each
    wait_pulse();
    check("slow overflow", n > 4090 && n < 4095, 1'b1);
    $display("test 4 done");
    report_and_stop();
  end
endmodule
